/* File: rswc_pkg.sv */
// package: constants, types and register map of the reset, sleep and wake-up controller
package rswc_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int POWERUP_DELAY_TIMER_TIME_MS  = 18;
    localparam int POWERUP_DELAY_TIMER_CYC      = (POWERUP_DELAY_TIMER_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int OST_CYC       = 128;
    localparam int CNT_W         = 18;

    // ------------------------------------------------------------------
    // register map (printed offsets are indices, byte address is 4x)
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [7:0]  REG_STATUS_IDX  = 8'h03;
    localparam logic [7:0]  REG_PCTRL_IDX   = 8'h08;
    localparam logic [7:0]  REG_WMASK_IDX   = 8'h09;
    localparam logic [7:0]  REG_IRQEN_IDX   = 8'h0e;
    localparam logic [7:0]  REG_IRQFLG_IDX  = 8'h0f;

    localparam int STAT_TO_BIT   = 4;
    localparam int STAT_PD_BIT   = 3;
    localparam int PCTRL_LVSEL   = 5;
    localparam int PCTRL_PC45MSK = 0;
    localparam int IRQ_LV_BIT    = 4;

    localparam logic [7:0] PCTRL_RST   = 8'h28;
    localparam logic [7:0] PCTRL_WMASK = 8'h3f;
    localparam logic [7:0] WMASK_RST   = 8'h00;
    localparam logic [7:0] IRQEN_RST   = 8'h00;
    localparam logic [7:0] IRQFLG_RST  = 8'h00;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {RS_HOLD, RS_POWERUP_DELAY_TIMER, RS_OST, RS_RUN, RS_SLEEP} rswc_fsm_e;

    typedef struct packed {
        logic       oscOk;
        logic       lowVolt;
        logic       extResetPin_n;
        logic       portcPin5;
        logic       portcPin4;
        logic [7:0] portbPins;
    } rswc_pins_s;

    localparam rswc_pins_s PINS_IDLE = '{oscOk: 1'b0, lowVolt: 1'b0, extResetPin_n: 1'b1,
                                         portcPin5: 1'b1, portcPin4: 1'b1,
                                         portbPins: 8'hff};

    typedef struct packed {
        rswc_fsm_e          fsm;
        logic               wakeOnly;
        logic [CNT_W-1:0]   cnt;
        logic               resetLatch;
        logic               ioHold;
        logic               oscOn;
        logic               coldReset;
        logic               timeoutFlag;
        logic               powerDownFlag;
        logic               wdtClr;
        logic               wakeResume;
        logic [7:0]         pctrl;
        logic [7:0]         wakeMask;
        logic [7:0]         irqEn;
        logic [7:0]         irqFlags;
        logic [31:0]        rdata;
        logic               slvErr;
        rswc_pins_s         sync1;
        rswc_pins_s         sync2;
        rswc_pins_s         prev;
    } rswc_state_s;

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] regAddr(input logic [7:0] idx);
        regAddr = {2'h0, idx, 2'h0};
    endfunction

endpackage

/* File: rswc_ctrl.sv */
// reset, sleep and wake-up controller with APB register slave
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - sleep clears powerdown, sets timeout, stops oscillator
// - pins held frozen while asleep
// - only pin reset, watchdog, brown-out, pin edge wake
// - unmasked input falling edge resumes at next instruction
// - pin or watchdog wake gives full reset
// - every wake waits delay plus start-up count
// - power-on, brown-out, pin, watchdog reset sources
// - low supply holds reset continuously
// - delay timer runs after every reset
// - start-up counter counts 128 once oscillator valid
// - latch set, timers cleared, then sequential release
// - some state survives warm resets
// - enables, flags, wake masks clear on reset
// - flag values depend on reset cause
// - events set or clear the two flags
// - low voltage sets flag bit 4, enable masks
// - select bit picks reset or interrupt
// - watchdog acts only when enabled
module rswc_ctrl
    import rswc_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYC
)(
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               cfgLowVoltEnable,
    input  wire logic               cfgPorta5OpenDrain,
    input  wire logic               cfgWatchdogEnable,
    input  wire logic               sleepInstr,
    input  wire logic               watchdogClearInstr,
    input  wire logic               watchdogTimeout,
    input  wire logic               extResetPin_n,
    input  wire logic               lowVoltDetect,
    input  wire logic               oscAmplitudeOk,
    input  wire logic [7:0]         portbPins,
    input  wire logic               portcPin4,
    input  wire logic               portcPin5,
    input  wire logic [7:0]         portbDirIn,
    input  wire logic               portcDirIn4,
    input  wire logic               portcDirIn5,
    output logic                    sysReset_n,
    output logic                    oscDriverOn,
    output logic                    ioHold,
    output logic                    wakeResume,
    output logic                    watchdogClr,
    output logic                    coldReset,
    output logic                    irq
);

    // ------------------------------------------------------------------
    // constants and state
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1);
    localparam logic [CNT_W-1:0] OST_LAST  = CNT_W'(OST_CYC - 1);

    localparam rswc_state_s ST_RST = '{
        fsm: RS_HOLD, wakeOnly: 1'b0, cnt: '0, resetLatch: 1'b1, ioHold: 1'b0,
        oscOn: 1'b1, coldReset: 1'b1, timeoutFlag: 1'b1, powerDownFlag: 1'b1,
        wdtClr: 1'b0, wakeResume: 1'b0, pctrl: PCTRL_RST, wakeMask: WMASK_RST,
        irqEn: IRQEN_RST, irqFlags: IRQFLG_RST, rdata: '0, slvErr: 1'b0,
        sync1: PINS_IDLE, sync2: PINS_IDLE, prev: PINS_IDLE};

    rswc_state_s st_r;
    rswc_state_s st_nxt;
    rswc_pins_s  pinsIn;
    logic        lowVoltNow;
    logic        borSrc;
    logic        pinSrc;
    logic        wdtSrc;
    logic        anySrc;
    logic [9:0]  fallEdge;
    logic [9:0]  wakeArmed;
    logic        wakeEvt;
    logic        lvRise;
    logic        lvIrqSet;
    logic        setupPh;
    logic        accessPh;

    // ------------------------------------------------------------------
    // source and wake decode from synchronised pins
    // ------------------------------------------------------------------
    always_comb
    begin
        pinsIn = '{oscOk: oscAmplitudeOk, lowVolt: lowVoltDetect,
                   extResetPin_n: extResetPin_n, portcPin5: portcPin5,
                   portcPin4: portcPin4, portbPins: portbPins};
    end

    assign lowVoltNow = st_r.sync2.lowVolt & cfgLowVoltEnable;
    assign borSrc     = lowVoltNow & st_r.pctrl[PCTRL_LVSEL];
    assign pinSrc     = ~st_r.sync2.extResetPin_n;
    assign wdtSrc     = watchdogTimeout & cfgWatchdogEnable;
    assign anySrc     = borSrc | pinSrc | wdtSrc;

    // falling edges on port B and port C pins 4/5; masked or output pins excluded
    assign fallEdge  = {st_r.prev.portcPin5 & ~st_r.sync2.portcPin5,
                        st_r.prev.portcPin4 & ~st_r.sync2.portcPin4,
                        st_r.prev.portbPins & ~st_r.sync2.portbPins};
    assign wakeArmed = {portcDirIn5 & ~st_r.pctrl[PCTRL_PC45MSK],
                        portcDirIn4 & ~st_r.pctrl[PCTRL_PC45MSK],
                        portbDirIn & ~st_r.wakeMask};
    assign wakeEvt   = |(fallEdge & wakeArmed);

    assign lvRise   = st_r.sync2.lowVolt & ~st_r.prev.lowVolt & cfgLowVoltEnable;
    assign lvIrqSet = lvRise & ~st_r.pctrl[PCTRL_LVSEL] & cfgPorta5OpenDrain
                      & st_r.irqEn[IRQ_LV_BIT];

    assign setupPh  = psel & ~penable;
    assign accessPh = psel & penable;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt            = st_r;
        st_nxt.sync1      = pinsIn;
        st_nxt.sync2      = st_r.sync1;
        st_nxt.prev       = st_r.sync2;
        st_nxt.wdtClr     = 1'b0;
        st_nxt.wakeResume = 1'b0;

        case (st_r.fsm)
            RS_HOLD:
            begin
                st_nxt.cnt = '0;
                st_nxt.fsm = RS_POWERUP_DELAY_TIMER;
            end
            RS_POWERUP_DELAY_TIMER:
            begin
                if (st_r.cnt == POWERUP_DELAY_TIMER_LAST)
                begin
                    st_nxt.cnt = '0;
                    st_nxt.fsm = RS_OST;
                end
                else
                begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            RS_OST:
            begin
                if (st_r.sync2.oscOk)
                begin
                    if (st_r.cnt == OST_LAST)
                    begin
                        st_nxt.cnt        = '0;
                        st_nxt.fsm        = RS_RUN;
                        st_nxt.wakeResume = st_r.wakeOnly;
                        st_nxt.wakeOnly   = 1'b0;
                    end
                    else
                    begin
                        st_nxt.cnt = st_r.cnt + 1'b1;
                    end
                end
            end
            RS_RUN:
            begin
                if (sleepInstr)
                begin
                    st_nxt.fsm           = RS_SLEEP;
                    st_nxt.timeoutFlag   = 1'b1;
                    st_nxt.powerDownFlag = 1'b0;
                    st_nxt.wdtClr        = 1'b1;
                end
                else if (watchdogClearInstr)
                begin
                    st_nxt.timeoutFlag   = 1'b1;
                    st_nxt.powerDownFlag = 1'b1;
                end
            end
            RS_SLEEP:
            begin
                if (wakeEvt)
                begin
                    st_nxt.fsm      = RS_POWERUP_DELAY_TIMER;
                    st_nxt.cnt      = '0;
                    st_nxt.wakeOnly = 1'b1;
                end
            end
            default:
            begin
                st_nxt.fsm = RS_HOLD;
            end
        endcase

        // any reset source overrides the sequence and restarts it
        if (anySrc)
        begin
            st_nxt.fsm      = RS_HOLD;
            st_nxt.cnt      = '0;
            st_nxt.wakeOnly = 1'b0;
            if (borSrc)
            begin
                st_nxt.timeoutFlag   = 1'b1;
                st_nxt.powerDownFlag = 1'b1;
                st_nxt.coldReset     = 1'b1;
            end
            else
            begin
                st_nxt.coldReset     = 1'b0;
                st_nxt.powerDownFlag = st_r.powerDownFlag;
                st_nxt.timeoutFlag   = st_r.timeoutFlag & ~wdtSrc;
            end
        end

        // registers: reset values loaded while the internal reset holds, else APB
        if (st_r.resetLatch)
        begin
            st_nxt.pctrl    = PCTRL_RST;
            st_nxt.wakeMask = WMASK_RST;
            st_nxt.irqEn    = IRQEN_RST;
            st_nxt.irqFlags = IRQFLG_RST;
        end
        else
        begin
            if (accessPh && pwrite)
            begin
                if (paddr == regAddr(REG_PCTRL_IDX))
                    st_nxt.pctrl = pwdata[7:0] & PCTRL_WMASK;
                if (paddr == regAddr(REG_WMASK_IDX))
                    st_nxt.wakeMask = pwdata[7:0];
                if (paddr == regAddr(REG_IRQEN_IDX))
                    st_nxt.irqEn = pwdata[7:0];
            end
            if (accessPh && !pwrite && paddr == regAddr(REG_IRQFLG_IDX))
                st_nxt.irqFlags = IRQFLG_RST;
            if (lvIrqSet)
                st_nxt.irqFlags[IRQ_LV_BIT] = 1'b1;
        end

        // read data captured in the setup cycle
        if (setupPh)
        begin
            st_nxt.rdata  = '0;
            st_nxt.slvErr = 1'b0;
            if (paddr == regAddr(REG_STATUS_IDX))
            begin
                st_nxt.rdata[STAT_TO_BIT] = st_r.timeoutFlag;
                st_nxt.rdata[STAT_PD_BIT] = st_r.powerDownFlag;
            end
            else if (paddr == regAddr(REG_PCTRL_IDX))
                st_nxt.rdata[7:0] = st_r.pctrl;
            else if (paddr == regAddr(REG_WMASK_IDX))
                st_nxt.rdata[7:0] = st_r.wakeMask;
            else if (paddr == regAddr(REG_IRQEN_IDX))
                st_nxt.rdata[7:0] = st_r.irqEn;
            else if (paddr == regAddr(REG_IRQFLG_IDX))
                st_nxt.rdata[7:0] = st_r.irqFlags & st_r.irqEn;
            else
                st_nxt.slvErr = 1'b1;
        end

        st_nxt.resetLatch = (st_nxt.fsm == RS_HOLD || st_nxt.fsm == RS_POWERUP_DELAY_TIMER
                             || st_nxt.fsm == RS_OST) && !st_nxt.wakeOnly;
        st_nxt.ioHold     = (st_nxt.fsm == RS_SLEEP) || st_nxt.wakeOnly;
        st_nxt.oscOn      = (st_nxt.fsm != RS_SLEEP);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata      = st_r.rdata;
    assign pready      = 1'b1;
    assign pslverr     = st_r.slvErr & accessPh;
    assign sysReset_n  = ~st_r.resetLatch;
    assign oscDriverOn = st_r.oscOn;
    assign ioHold      = st_r.ioHold;
    assign wakeResume  = st_r.wakeResume;
    assign watchdogClr = st_r.wdtClr;
    assign coldReset   = st_r.coldReset;
    assign irq         = |(st_r.irqFlags & st_r.irqEn);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_ostLast;
        st_r.fsm == RS_OST && st_r.cnt == OST_LAST && st_r.sync2.oscOk && !anySrc;
    endsequence
    sequence s_released;
        st_r.fsm == RS_RUN && st_r.cnt == '0;
    endsequence

    property p_sleepEntry;
        st_r.fsm == RS_RUN && sleepInstr && !anySrc |=>
            st_r.fsm == RS_SLEEP && !st_r.powerDownFlag && st_r.timeoutFlag
            && watchdogClr && !oscDriverOn;
    endproperty
    a_sleepEntry: assert property (p_sleepEntry) else $error("sleep entry wrong");

    property p_holdPins;
        st_r.fsm == RS_SLEEP |-> ioHold;
    endproperty
    a_holdPins: assert property (p_holdPins) else $error("pins not held");

    property p_stayAsleep;
        st_r.fsm == RS_SLEEP && !wakeEvt && !anySrc |=> st_r.fsm == RS_SLEEP;
    endproperty
    a_stayAsleep: assert property (p_stayAsleep) else $error("spurious wake");

    property p_pinWake;
        st_r.fsm == RS_SLEEP && wakeEvt && !anySrc |=>
            st_r.fsm == RS_POWERUP_DELAY_TIMER && sysReset_n && ioHold;
    endproperty
    a_pinWake: assert property (p_pinWake) else $error("pin wake wrong");

    property p_resetWake;
        st_r.fsm == RS_SLEEP && (pinSrc || wdtSrc) |=> !sysReset_n && st_r.fsm == RS_HOLD;
    endproperty
    a_resetWake: assert property (p_resetWake) else $error("wake not reset");

    property p_release;
        s_ostLast ##1 s_released |-> sysReset_n && !ioHold;
    endproperty
    a_release: assert property (p_release) else $error("release wrong");

    property p_brownout;
        borSrc |=> !sysReset_n && st_r.fsm == RS_HOLD && st_r.cnt == '0;
    endproperty
    a_brownout: assert property (p_brownout) else $error("no brown-out hold");

    property p_ostGate;
        st_r.fsm == RS_OST && !st_r.sync2.oscOk && !anySrc |=> $stable(st_r.cnt);
    endproperty
    a_ostGate: assert property (p_ostGate) else $error("start-up count ran");

    property p_wdtFlags;
        wdtSrc && !borSrc |=> !st_r.timeoutFlag && $stable(st_r.powerDownFlag);
    endproperty
    a_wdtFlags: assert property (p_wdtFlags) else $error("watchdog flags wrong");

    property p_lvIrq;
        lvIrqSet && !st_r.resetLatch |=> st_r.irqFlags[IRQ_LV_BIT] ##0 irq;
    endproperty
    a_lvIrq: assert property (p_lvIrq) else $error("low-voltage flag missed");

    property p_wdtDisabled;
        watchdogTimeout && !cfgWatchdogEnable && !borSrc && !pinSrc
            && st_r.fsm == RS_RUN |=> st_r.fsm != RS_HOLD;
    endproperty
    a_wdtDisabled: assert property (p_wdtDisabled) else $error("disabled watchdog reset");

endmodule

`default_nettype wire

/* File: tb.sv */
// self-checking testbench of the reset, sleep and wake-up controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rswc_pkg::*;
    localparam int PW = 20;
    logic              mclk, rst_n, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, err, cfgLowVoltEnable, cfgPorta5OpenDrain;
    logic              cfgWatchdogEnable, sleepInstr, watchdogClearInstr, watchdogTimeout;
    logic              extResetPin_n, lowVoltDetect, oscAmplitudeOk, portcPin4, portcPin5;
    logic [7:0]        portbPins, portbDirIn;
    logic              portcDirIn4, portcDirIn5, sysReset_n, oscDriverOn, ioHold;
    logic              wakeResume, watchdogClr, coldReset, irq, lowSeen;
    int                nFail, checks, n;

    rswc_ctrl #(.POWERUP_DELAY_TIMER_CYCLES(PW)) i_rswc_ctrl (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfgLowVoltEnable(cfgLowVoltEnable),
        .cfgPorta5OpenDrain(cfgPorta5OpenDrain), .cfgWatchdogEnable(cfgWatchdogEnable),
        .sleepInstr(sleepInstr), .watchdogClearInstr(watchdogClearInstr),
        .watchdogTimeout(watchdogTimeout), .extResetPin_n(extResetPin_n),
        .lowVoltDetect(lowVoltDetect), .oscAmplitudeOk(oscAmplitudeOk), .portbPins(portbPins),
        .portcPin4(portcPin4), .portcPin5(portcPin5), .portbDirIn(portbDirIn),
        .portcDirIn4(portcDirIn4), .portcDirIn5(portcDirIn5), .sysReset_n(sysReset_n),
        .oscDriverOn(oscDriverOn), .ioHold(ioHold), .wakeResume(wakeResume),
        .watchdogClr(watchdogClr), .coldReset(coldReset), .irq(irq));

    // ------------------------------------------------------------------
    // tasks: every task starts and ends just after a rising edge
    // ------------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            nFail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, nFail);
        if (nFail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        cmp(rd, exp);
    endtask

    task automatic bit1(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask

    task automatic goSleep;
        sleepInstr <= 1'b1;
        @(posedge mclk);
        sleepInstr <= 1'b0;
        n = 0;
        repeat (3)
        begin
            @(posedge mclk);
            n += int'(watchdogClr === 1'b1);
        end
        cmp(n, 1);
        bit1(oscDriverOn, 1'b0);
        bit1(ioHold, 1'b1);
    endtask

    task automatic wdPulse;
        watchdogTimeout <= 1'b1;
        @(posedge mclk);
        watchdogTimeout <= 1'b0;
        cyc(3);
    endtask

    // checks reset is held, times its release, then reads the flags
    task automatic relCheck(input int lo, input logic [31:0] st, input logic cold);
        bit1(sysReset_n, 1'b0);
        n = 0;
        while (sysReset_n !== 1'b1 && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        bit1(n >= lo && n <= lo + 12, 1'b1);
        rdc(REG_STATUS_IDX, st);
        bit1(coldReset, cold);
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial
    begin
        #3000000;
        nFail++;
        report_and_stop();
    end

    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {sleepInstr, watchdogClearInstr, watchdogTimeout, lowVoltDetect, oscAmplitudeOk} = '0;
        {cfgLowVoltEnable, cfgPorta5OpenDrain, cfgWatchdogEnable, extResetPin_n} = 4'hf;
        {portcPin4, portcPin5, portcDirIn4, portcDirIn5} = 4'hf;
        portbPins  = 8'hff;
        portbDirIn = 8'hfe;
        nFail  = 0;
        checks = 0;
        cyc(16);
        rst_n <= 1'b1;
        cyc(2);
        apb(1'b1, REG_PCTRL_IDX, 8'h00);
        rdc(REG_PCTRL_IDX, 32'h28);
        rdc(REG_WMASK_IDX, 32'h00);
        rdc(REG_IRQEN_IDX, 32'h00);
        rdc(REG_IRQFLG_IDX, 32'h00);
        cyc(300);
        oscAmplitudeOk <= 1'b1;
        relCheck(124, 32'h18, 1'b1);
        apb(1'b1, REG_PCTRL_IDX, 8'hff);
        rdc(REG_PCTRL_IDX, 32'h3f);
        apb(1'b1, REG_WMASK_IDX, 8'h5a);
        rdc(REG_WMASK_IDX, 32'h5a);
        apb(1'b1, REG_IRQEN_IDX, 8'h10);
        rdc(REG_IRQEN_IDX, 32'h10);
        apb(1'b1, REG_STATUS_IDX, 8'h00);
        rdc(REG_STATUS_IDX, 32'h18);
        apb(1'b0, 8'h20, 8'h00);
        bit1(err, 1'b1);
        apb(1'b1, REG_PCTRL_IDX, 8'h01);
        lowVoltDetect <= 1'b1;
        cyc(6);
        bit1(irq, 1'b1);
        lowVoltDetect <= 1'b0;
        rdc(REG_IRQFLG_IDX, 32'h10);
        rdc(REG_IRQFLG_IDX, 32'h00);
        bit1(irq, 1'b0);
        cfgPorta5OpenDrain <= 1'b0;
        lowVoltDetect      <= 1'b1;
        cyc(6);
        lowVoltDetect <= 1'b0;
        rdc(REG_IRQFLG_IDX, 32'h00);
        goSleep();
        rdc(REG_STATUS_IDX, 32'h10);
        portbPins <= 8'hf4;
        portcPin4 <= 1'b0;
        cyc(20);
        bit1(oscDriverOn, 1'b0);
        portbPins <= 8'hff;
        portcPin4 <= 1'b1;
        cyc(4);
        portbPins <= 8'hfb;
        n       = 0;
        lowSeen = 1'b0;
        while (wakeResume !== 1'b1 && n < 2000)
        begin
            @(posedge mclk);
            n++;
            lowSeen |= (sysReset_n !== 1'b1);
        end
        bit1(n >= PW + 128 && n <= PW + 140, 1'b1);
        bit1(lowSeen, 1'b0);
        portbPins <= 8'hff;
        cyc(1);
        bit1(ioHold, 1'b0);
        rdc(REG_STATUS_IDX, 32'h10);
        goSleep();
        wdPulse();
        relCheck(PW + 122, 32'h00, 1'b0);
        rdc(REG_WMASK_IDX, 32'h00);
        watchdogClearInstr <= 1'b1;
        @(posedge mclk);
        watchdogClearInstr <= 1'b0;
        cyc(2);
        rdc(REG_STATUS_IDX, 32'h18);
        wdPulse();
        relCheck(PW + 122, 32'h08, 1'b0);
        extResetPin_n <= 1'b0;
        cyc(4);
        extResetPin_n <= 1'b1;
        cyc(1);
        relCheck(PW + 122, 32'h08, 1'b0);
        goSleep();
        extResetPin_n <= 1'b0;
        cyc(4);
        extResetPin_n <= 1'b1;
        cyc(1);
        relCheck(PW + 122, 32'h10, 1'b0);
        cfgWatchdogEnable <= 1'b0;
        wdPulse();
        bit1(sysReset_n, 1'b1);
        cfgLowVoltEnable <= 1'b0;
        lowVoltDetect    <= 1'b1;
        cyc(6);
        bit1(sysReset_n, 1'b1);
        cfgLowVoltEnable <= 1'b1;
        cyc(60);
        bit1(sysReset_n, 1'b0);
        lowVoltDetect <= 1'b0;
        cyc(3);
        relCheck(PW + 122, 32'h18, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
